//--- design/fsc_pkg.sv
// shared constants for the bubble formatter and sense channel
package fsc_pkg;
  localparam int          BLOCK_BITS = 320;
  localparam int          DATA_BITS  = 256;
  localparam int          CHECK_BITS = 14;
  localparam int          ECC_GOOD   = 270;
  localparam int          PLAIN_GOOD = 272;
  localparam int          BURST_MAX  = 5;
  localparam logic [13:0] GEN_POLY   = 14'h0A25;
  localparam logic [13:0] CRC_RESET  = 14'h0000;
  localparam int          CLK_NS     = 25;
  localparam int          CONV_NS    = 100;
  localparam int          CONV_CYC   = (CONV_NS + CLK_NS - 1) / CLK_NS;
  localparam int          ROT_NS     = 10000;
  localparam int          ROT_CYC    = ROT_NS / CLK_NS;
  localparam int          ROT_HOLD   = 2;
  localparam int          STAMP_W    = 3;
  localparam int          PTR_W      = 9;
  localparam int          FIFO_DEPTH = 8;

  typedef enum logic [0:0] {
    ECC_RUN  = 1'b0,
    ECC_TRAP = 1'b1
  } ecc_state_t;
endpackage

//--- design/bit_fifo.sv
// small synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
module bit_fifo
  import fsc_pkg::*;
#(
  parameter int WIDTH = 4,
  parameter int DEPTH = FIFO_DEPTH
)
(
  input  wire logic             sys_clk,
  input  wire logic             reset,
  input  wire logic             clk_en,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wp_q;
  logic [AW-1:0]    rp_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_q != FULL);
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rp_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge sys_clk)
  begin
    if (clk_en && push)
      mem_q[wp_q] <= in_data;
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end
    else if (clk_en)
    begin
      if (flush)
      begin
        wp_q  <= '0;
        rp_q  <= '0;
        cnt_q <= '0;
      end
      else
      begin
        if (push)
          wp_q <= (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
        if (pop)
          rp_q <= (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
        cnt_q <= cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
      end
    end
  end
endmodule

//--- design/formatter_sense_channel.sv
// one bubble channel: sense, write gating, good-bit format, burst code
`timescale 1ns/10ps
module formatter_sense_channel
  import fsc_pkg::*;
#(
  parameter int ROT_CYCLES = ROT_CYC,
  parameter int DEPTH      = FIFO_DEPTH
)
(
  input  wire logic sys_clk,
  input  wire logic reset,
  input  wire logic clk_en,
  input  wire logic shift_strobe_n,
  input  wire logic det_p,
  input  wire logic det_n,
  input  wire logic sync_pulse,
  input  wire logic write_mode,
  input  wire logic ecc_enable,
  input  wire logic soft_reset,
  input  wire logic err_status_read,
  input  wire logic mask_load_valid,
  input  wire logic mask_load_bit,
  input  wire logic host_wr_valid,
  input  wire logic host_wr_bit,
  output logic      host_wr_ready,
  output logic      host_rd_valid,
  output logic      host_rd_bit,
  input  wire logic host_rd_ready,
  output logic      data_out,
  output logic      error_alert_n_o,
  output logic      error_alert_n_oe,
  output logic      corr_err,
  output logic      uncorr_err
);
  localparam int CONV_DLY = CONV_CYC;
  localparam logic [PTR_W-1:0] PTR_END = PTR_W'(BLOCK_BITS - 1);
  localparam logic [PTR_W-1:0] CONV_LD = PTR_W'(CONV_CYC);

  // pins: {sync, det_n, det_p, strobe_n}; three flops, 2nd/3rd agree
  logic [3:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_lvl_q;
  logic [3:0] pin_agree;
  logic       strobe_act, det_bit, sync_lvl, sync_prev_q;
  logic       strobe_prev_q, trail, sync_rise;

  assign pin_agree = ~(pin_s2_q ^ pin_s3_q);

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      pin_s1_q  <= 4'h1;
      pin_s2_q  <= 4'h1;
      pin_s3_q  <= 4'h1;
      pin_lvl_q <= 4'h1;
    end
    else if (clk_en)
    begin
      pin_s1_q  <= {sync_pulse, det_n, det_p, shift_strobe_n};
      pin_s2_q  <= pin_s1_q;
      pin_s3_q  <= pin_s2_q;
      pin_lvl_q <= (pin_agree & pin_s3_q) | (~pin_agree & pin_lvl_q);
    end
  end

  assign strobe_act = ~pin_lvl_q[0];
  assign det_bit    = pin_lvl_q[1] & ~pin_lvl_q[2];
  assign sync_lvl   = pin_lvl_q[3];
  assign trail      = strobe_prev_q && !strobe_act;
  assign sync_rise  = sync_lvl && !sync_prev_q;

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      strobe_prev_q <= 1'b0;
      sync_prev_q   <= 1'b0;
    end
    else if (clk_en)
    begin
      strobe_prev_q <= strobe_act;
      sync_prev_q   <= sync_lvl;
    end
  end

  // field rotation timebase, restarted by each sync
  logic [PTR_W:0]       rot_cnt_q;
  logic [STAMP_W-1:0]   rot_num_q;

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      rot_cnt_q <= '0;
      rot_num_q <= '0;
    end
    else if (clk_en)
    begin
      if (sync_rise || rot_cnt_q == (PTR_W + 1)'(ROT_CYCLES - 1))
      begin
        rot_cnt_q <= '0;
        rot_num_q <= rot_num_q + 1'b1;
      end
      else
        rot_cnt_q <= rot_cnt_q + 1'b1;
    end
  end

  // loop mask, loaded serially by the controller
  logic [BLOCK_BITS-1:0] mask_q;
  logic [PTR_W-1:0]      mask_ptr_q, good_cnt_q, lim;
  logic                  good_now, ck_slot;

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      mask_q <= '0;
    else if (clk_en && mask_load_valid)
      mask_q <= {mask_load_bit, mask_q[BLOCK_BITS-1:1]};
  end

  assign lim      = ecc_enable ? PTR_W'(ECC_GOOD) : PTR_W'(PLAIN_GOOD);
  assign good_now = mask_q[mask_ptr_q] && (good_cnt_q < lim);
  assign ck_slot  = ecc_enable && (good_cnt_q >= PTR_W'(DATA_BITS));

  // position 2k is odd half of loop k+1, 2k+1 its even half
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      mask_ptr_q <= '0;
      good_cnt_q <= '0;
    end
    else if (clk_en)
    begin
      if (soft_reset)
      begin
        mask_ptr_q <= '0;
        good_cnt_q <= '0;
      end
      else if (trail)
      begin
        mask_ptr_q <= (mask_ptr_q == PTR_END) ? '0 : mask_ptr_q + 1'b1;
        if (mask_ptr_q == PTR_END)
          good_cnt_q <= '0;
        else if (good_now)
          good_cnt_q <= good_cnt_q + 1'b1;
      end
    end
  end

  // read: sample, hold, convert, latch
  logic             sample_q, latch_full_q, lat_good_q;
  logic [PTR_W-1:0] conv_cnt_q, lat_idx_q;
  logic             conv_done;

  assign conv_done = (conv_cnt_q == PTR_W'(1));

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      sample_q   <= 1'b0;
      conv_cnt_q <= '0;
      lat_good_q <= 1'b0;
      lat_idx_q  <= '0;
    end
    else if (clk_en)
    begin
      if (strobe_act && !write_mode)
        sample_q <= det_bit;
      if (trail && !write_mode)
      begin
        conv_cnt_q <= CONV_LD;
        lat_good_q <= good_now;
        lat_idx_q  <= good_cnt_q;
      end
      else if (conv_cnt_q != '0)
        conv_cnt_q <= conv_cnt_q - 1'b1;
    end
  end

  // latch waits for FIFO room; a later conversion overwrites it
  logic             f_in_valid, f_in_ready, f_out_valid, f_out_ready;
  logic [STAMP_W:0] f_in_data, f_out_data;
  logic [STAMP_W:0] lat_word_q;
  logic             aged, drove_q, wr_bit, avail;

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      latch_full_q <= 1'b0;
      lat_word_q   <= '0;
    end
    else if (clk_en)
    begin
      if (soft_reset)
        latch_full_q <= 1'b0;
      else if (conv_done)
      begin
        // stamp is the rotation of the latch, never earlier than the strobe
        latch_full_q <= lat_good_q && (lat_idx_q < lim);
        lat_word_q   <= {rot_num_q, sample_q};
      end
      else if (f_in_valid && f_in_ready && !write_mode)
        latch_full_q <= 1'b0;
    end
  end

  assign f_in_valid  = write_mode ? host_wr_valid : latch_full_q;
  assign f_in_data   = write_mode ? {rot_num_q, host_wr_bit} : lat_word_q;
  assign host_wr_ready = write_mode && f_in_ready;
  assign aged = (STAMP_W'(rot_num_q - f_out_data[STAMP_W:1])
                 >= STAMP_W'(ROT_HOLD));
  assign host_rd_valid = !write_mode && f_out_valid && aged;
  assign host_rd_bit   = f_out_data[0];
  assign f_out_ready = write_mode ? (trail && drove_q)
                                  : (host_rd_ready && aged);

  bit_fifo #(.WIDTH(STAMP_W + 1), .DEPTH(DEPTH)) u_fifo
  (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .clk_en    (clk_en),
    .flush     (soft_reset),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .in_data   (f_in_data),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out_data)
  );

  // write: check bits follow the 256 data bits of a coded block
  logic [13:0] crc_q, rcv_q, syn_q;
  assign avail  = ck_slot || (f_out_valid && aged);
  assign wr_bit = ck_slot ? crc_q[13] : f_out_data[0];

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      data_out <= 1'b1;
      drove_q  <= 1'b0;
    end
    else if (clk_en)
    begin
      if (strobe_act && write_mode && good_now && avail)
      begin
        data_out <= wr_bit;
        drove_q  <= !ck_slot;
      end
      else
      begin
        data_out <= 1'b1;
        if (!strobe_act)
          drove_q <= drove_q && !trail;
        else
          drove_q <= 1'b0;
      end
    end
  end

  function automatic logic [13:0] crc_step(input logic [13:0] c,
                                           input logic        fb);
    crc_step = {c[12:0], 1'b0} ^ (fb ? GEN_POLY : CRC_RESET);
  endfunction

  logic       chk_evt, syn_zero;
  logic [13:0] syn_new;
  assign chk_evt  = !write_mode && ecc_enable && conv_done && lat_good_q
                    && lat_idx_q == PTR_W'(ECC_GOOD - 1);
  assign syn_new  = crc_q ^ {rcv_q[12:0], sample_q};
  assign syn_zero = (syn_new == CRC_RESET);

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      crc_q <= CRC_RESET;
      rcv_q <= CRC_RESET;
    end
    else if (clk_en)
    begin
      if (soft_reset || chk_evt || (write_mode && trail && mask_ptr_q == PTR_END))
        crc_q <= CRC_RESET;
      else if (write_mode && trail && good_now && ck_slot)
        crc_q <= crc_step(crc_q, 1'b0);
      else if (write_mode && trail && drove_q && ecc_enable)
        crc_q <= crc_step(crc_q, f_out_data[0] ^ crc_q[13]);
      else if (!write_mode && conv_done && lat_good_q && ecc_enable)
      begin
        if (lat_idx_q < PTR_W'(DATA_BITS))
          crc_q <= crc_step(crc_q, sample_q ^ crc_q[13]);
        else
          rcv_q <= {rcv_q[12:0], sample_q};
      end
    end
  end

  // error trapping: a short burst lands in the low bits within n shifts;
  // flags only, already delivered bits are not repaired
  ecc_state_t       ecc_q;
  logic [PTR_W-1:0] trap_cnt_q;
  logic             corr_set, uncorr_set, err_q;

  assign corr_set   = (ecc_q == ECC_TRAP) && (syn_q[13:BURST_MAX] == '0);
  assign uncorr_set = (ecc_q == ECC_TRAP) && !corr_set
                      && trap_cnt_q == PTR_W'(ECC_GOOD - 1);

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      ecc_q      <= ECC_RUN;
      syn_q      <= CRC_RESET;
      trap_cnt_q <= '0;
    end
    else if (clk_en)
    begin
      unique case (ecc_q)
        ECC_RUN:
        begin
          trap_cnt_q <= '0;
          if (chk_evt && !syn_zero)
          begin
            syn_q <= syn_new;
            ecc_q <= ECC_TRAP;
          end
        end
        ECC_TRAP:
        begin
          syn_q      <= crc_step(syn_q, syn_q[13]);
          trap_cnt_q <= trap_cnt_q + 1'b1;
          if (corr_set || uncorr_set || soft_reset)
            ecc_q <= ECC_RUN;
        end
      endcase
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      corr_err   <= 1'b0;
      uncorr_err <= 1'b0;
      err_q      <= 1'b0;
    end
    else if (clk_en)
    begin
      corr_err   <= corr_set || (corr_err && !(err_status_read || soft_reset));
      uncorr_err <= uncorr_set
                    || (uncorr_err && !(err_status_read || soft_reset));
      err_q      <= corr_set || uncorr_set
                    || (err_q && !(err_status_read || soft_reset));
    end
  end

  assign error_alert_n_o  = 1'b0;
  assign error_alert_n_oe = err_q;

  property p_idle_high;
    @(posedge sys_clk) disable iff (reset || !clk_en)
      !strobe_act ##1 !strobe_act |-> data_out;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("output not high");

  property p_conv_start;
    @(posedge sys_clk) disable iff (reset || !clk_en)
      trail && !write_mode |=> conv_cnt_q == CONV_LD;
  endproperty
  a_conv_start: assert property (p_conv_start) else $error("no conversion");

  property p_latch_time;
    @(posedge sys_clk) disable iff (reset || !clk_en)
      trail && !write_mode |-> ##CONV_DLY conv_done;
  endproperty
  a_latch_time: assert property (p_latch_time) else $error("late latch");

  property p_hold;
    @(posedge sys_clk) disable iff (reset || !clk_en)
      !strobe_act && $past(!strobe_act) |-> $stable(sample_q);
  endproperty
  a_hold: assert property (p_hold) else $error("sample moved");

  property p_ptr_adv;
    @(posedge sys_clk) disable iff (reset || !clk_en)
      trail && !soft_reset && mask_ptr_q != PTR_END
        |=> mask_ptr_q == $past(mask_ptr_q) + 1'b1;
  endproperty
  a_ptr_adv: assert property (p_ptr_adv) else $error("pointer stuck");

  property p_rd_age;
    @(posedge sys_clk) disable iff (reset || !clk_en)
      host_rd_valid
        |-> STAMP_W'(rot_num_q - f_out_data[STAMP_W:1]) >= STAMP_W'(ROT_HOLD);
  endproperty
  a_rd_age: assert property (p_rd_age) else $error("read too early");

  property p_err_set;
    @(posedge sys_clk) disable iff (reset || !clk_en)
      corr_set || uncorr_set |=> error_alert_n_oe ##1 1'b1;
  endproperty
  a_err_set: assert property (p_err_set) else $error("flag not raised");

  property p_err_clr;
    @(posedge sys_clk) disable iff (reset || !clk_en)
      err_status_read && !corr_set && !uncorr_set |=> !error_alert_n_oe;
  endproperty
  a_err_clr: assert property (p_err_clr) else $error("flag not released");

  property p_depth;
    @(posedge sys_clk) disable iff (reset || !clk_en)
      good_cnt_q <= (ecc_enable ? ECC_GOOD : PLAIN_GOOD);
  endproperty
  a_depth: assert property (p_depth) else $error("depth exceeded");

  property p_trap_bound;
    @(posedge sys_clk) disable iff (reset || !clk_en)
      ecc_q == ECC_TRAP |-> trap_cnt_q < PTR_W'(ECC_GOOD);
  endproperty
  a_trap_bound: assert property (p_trap_bound) else $error("trap overrun");

  c_rd_bit: cover property (@(posedge sys_clk) host_rd_valid && host_rd_ready);
  c_wr_bit: cover property (@(posedge sys_clk) strobe_act && !data_out);
  c_corr: cover property (@(posedge sys_clk) corr_set);
  c_uncorr: cover property (@(posedge sys_clk) uncorr_set);
endmodule

//--- dv/bubble_partner.sv
// controller and detector bridge model facing one bubble channel
`timescale 1ns/10ps
module bubble_partner
(
  input  wire logic sys_clk,
  input  wire logic data_out,
  output logic      shift_strobe_n,
  output logic      det_p,
  output logic      det_n,
  output logic      sync_pulse
);
  logic gen_pulse;
  logic last_out;

  initial
  begin
    shift_strobe_n = 1'b1;
    det_p          = 1'b0;
    det_n          = 1'b1;
    sync_pulse     = 1'b0;
    gen_pulse      = 1'b0;
    last_out       = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask

  // held four cycles so the pin synchroniser sees it
  task automatic send_sync();
    tick(1);
    sync_pulse = 1'b1;
    tick(4);
    sync_pulse = 1'b0;
  endtask

  // one bit time; the bridge shows the bit only around the strobe
  task automatic strobe(input logic b);
    tick(1);
    shift_strobe_n = 1'b0;
    det_p          = b;
    det_n          = ~b;
    tick(2);
    gen_pulse = 1'b1;
    tick(2);
    gen_pulse = 1'b0;
    tick(4);
    last_out       = data_out;
    shift_strobe_n = 1'b1;
    tick(2);
    det_p = ~b;
    det_n = b;
    tick(6);
  endtask
endmodule

//--- dv/tb.sv
// self-checking bench for the bubble formatter and sense channel
`timescale 1ns/10ps
module tb
  import fsc_pkg::*;
;
  // short rotation; stamps wrap every 800 cycles, within the block tests but after any bit waits in the read and write tests
  localparam int ROT = 100;

  logic         sys_clk;
  logic         reset           = 1'b1;
  logic         clk_en          = 1'b1;
  logic         write_mode      = 1'b0;
  logic         ecc_enable      = 1'b0;
  logic         soft_reset      = 1'b0;
  logic         err_status_read = 1'b0;
  logic         mask_load_valid = 1'b0;
  logic         mask_load_bit   = 1'b0;
  logic         host_wr_valid   = 1'b0;
  logic         host_wr_bit     = 1'b0;
  logic         host_rd_ready   = 1'b0;
  logic         shift_strobe_n, det_p, det_n, sync_pulse;
  logic         host_wr_ready, host_rd_valid, host_rd_bit, data_out;
  logic         error_alert_n_o, error_alert_n_oe, corr_err, uncorr_err;
  logic         error_alert_n;
  logic [319:0] mask, cw;
  int           failures = 0;
  int           checked  = 0;
  int           cycles   = 0;

  // pull-up on the open-drain flag
  assign error_alert_n = error_alert_n_oe ? error_alert_n_o : 1'b1;

  formatter_sense_channel #(.ROT_CYCLES(ROT), .DEPTH(FIFO_DEPTH)) dut
  (
    .sys_clk(sys_clk), .reset(reset), .clk_en(clk_en),
    .shift_strobe_n(shift_strobe_n), .det_p(det_p), .det_n(det_n),
    .sync_pulse(sync_pulse), .write_mode(write_mode),
    .ecc_enable(ecc_enable), .soft_reset(soft_reset),
    .err_status_read(err_status_read),
    .mask_load_valid(mask_load_valid), .mask_load_bit(mask_load_bit),
    .host_wr_valid(host_wr_valid), .host_wr_bit(host_wr_bit),
    .host_wr_ready(host_wr_ready), .host_rd_valid(host_rd_valid),
    .host_rd_bit(host_rd_bit), .host_rd_ready(host_rd_ready),
    .data_out(data_out), .error_alert_n_o(error_alert_n_o),
    .error_alert_n_oe(error_alert_n_oe), .corr_err(corr_err),
    .uncorr_err(uncorr_err)
  );

  bubble_partner ctl
  (
    .sys_clk(sys_clk), .data_out(data_out),
    .shift_strobe_n(shift_strobe_n), .det_p(det_p), .det_n(det_n),
    .sync_pulse(sync_pulse)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      failures++;
      summarize();
    end
  end

  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask

  task automatic check(input logic seen, input logic exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h",
               $time, seen, exp);
    end
  endtask

  task automatic pulse_soft();
    soft_reset = 1'b1;
    step(1);
    soft_reset = 1'b0;
    step(2);
  endtask

  task automatic load_mask(input logic [319:0] m);
    mask_load_valid = 1'b1;
    for (int i = 0; i < BLOCK_BITS; i++)
    begin
      mask_load_bit = m[i];
      step(1);
    end
    mask_load_valid = 1'b0;
    step(1);
  endtask

  task automatic pop(output logic b);
    int n;
    n = 0;
    while (host_rd_valid !== 1'b1 && n < 200)
    begin
      step(1);
      n++;
    end
    check(host_rd_valid, 1'b1);
    b = host_rd_bit;
    host_rd_ready = 1'b1;
    step(1);
    host_rd_ready = 1'b0;
    step(1);
  endtask

  // data bits first in order, remainder sent high order first
  function automatic logic [319:0] codeword();
    logic [319:0] c;
    logic [13:0]  r;
    logic         fb;
    c = '1;
    r = CRC_RESET;
    for (int i = 0; i < DATA_BITS; i++)
    begin
      c[i] = (i % 3 == 0);
      fb = c[i] ^ r[13];
      r = {r[12:0], 1'b0} ^ (fb ? GEN_POLY : 14'h0000);
    end
    for (int j = 0; j < CHECK_BITS; j++)
      c[DATA_BITS + j] = r[13 - j];
    return c;
  endfunction

  task automatic test_reset();
    check(data_out, 1'b1);
    check(error_alert_n, 1'b1);
    check(corr_err | uncorr_err, 1'b0);
    check(host_rd_valid, 1'b0);
    check(host_wr_ready, 1'b0);
    $display("test reset done");
  endtask

  task automatic test_read();
    logic [5:0] bits;
    logic       b;
    bits = 6'b101101;
    mask = '1;
    mask[2] = 1'b0;
    load_mask(mask);
    pulse_soft();
    ctl.send_sync();
    ctl.strobe(bits[0]);
    step(4);
    check(host_rd_valid, 1'b0);
    for (int i = 1; i < 6; i++)
      ctl.strobe(bits[i]);
    // one rotation start has passed: first bit still too young
    check(host_rd_valid, 1'b0);
    step(3 * ROT);
    for (int i = 0; i < 6; i++)
      if (i != 2)
      begin
        pop(b);
        check(b, bits[i]);
      end
    check(host_rd_valid, 1'b0);
    $display("test read done");
  endtask

  task automatic test_write();
    logic [7:0] w;
    logic       e;
    int         k;
    w = 8'hB4;
    pulse_soft();
    write_mode = 1'b1;
    step(1);
    ctl.send_sync();
    host_wr_valid = 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      check(host_wr_ready, 1'b1);
      host_wr_bit = w[i];
      step(1);
    end
    host_wr_valid = 1'b0;
    check(host_wr_ready, 1'b0);
    // too young: pin stays high and the bit is kept
    ctl.strobe(1'b0);
    check(ctl.last_out, 1'b1);
    step(3 * ROT);
    k = 0;
    for (int pos = 1; pos < 11; pos++)
    begin
      ctl.strobe(1'b0);
      e = 1'b1;
      if (pos != 2 && k < 8)
      begin
        e = w[k];
        k++;
      end
      check(ctl.last_out, e);
      check(data_out, 1'b1);
    end
    write_mode = 1'b0;
    $display("test write done");
  endtask

  task automatic test_block(input logic [319:0] blk, input logic err,
                            input logic by_status, input string name);
    ecc_enable = 1'b1;
    pulse_soft();
    ctl.send_sync();
    for (int i = 0; i < BLOCK_BITS; i++)
      ctl.strobe(blk[i]);
    step(400);
    check(corr_err, err);
    check(uncorr_err, 1'b0);
    check(error_alert_n, ~err);
    // frozen block ignores a status read
    clk_en = 1'b0;
    err_status_read = 1'b1;
    step(2);
    err_status_read = 1'b0;
    clk_en = 1'b1;
    check(error_alert_n, ~err);
    if (by_status)
    begin
      err_status_read = 1'b1;
      step(1);
      err_status_read = 1'b0;
    end
    else
      pulse_soft();
    step(2);
    check(error_alert_n, 1'b1);
    check(corr_err, 1'b0);
    $display("test %s done", name);
  endtask

  initial
  begin
    step(4);
    reset = 1'b0;
    step(1);
    test_reset();
    test_read();
    test_write();
    mask = '0;
    mask[269:0] = '1;
    load_mask(mask);
    cw = codeword();
    test_block(cw, 1'b0, 1'b1, "clean block");
    test_block(cw ^ (320'h1F << 100), 1'b1, 1'b1, "burst");
    test_block(cw ^ (320'h1 << 200), 1'b1, 1'b0, "single");
    summarize();
  end
endmodule
